// [rdbc_pkg.sv]
/*
 Package for the rate decimation and burst read control block:
 register offset, field positions, reset value, divide table.
 Assumes an 8-bit register access port on the same clock as the block.
*/
package rdbc_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] CTRL_OFFSET      = 8'h30;
   localparam logic [7:0] CTRL_RESET       = 8'h00;
   localparam int         DIV_LSB          = 0;
   localparam int         WRAP_DIS_BIT     = 4;
   localparam int         WRAP_SEL_BIT     = 5;
   localparam int         RSVD_BIT         = 6;
   localparam int         BURST_BIT        = 7;
   // ==========================================================
   // Address pointer wrap points
   localparam logic [7:0] WRAP_TARGET      = 8'h0d;
   localparam logic [7:0] WRAP_LOW_END     = 8'h12;
   localparam logic [7:0] WRAP_HIGH_END    = 8'h14;
   // ==========================================================
   // Sample framing
   localparam logic [2:0] SAMPLE_BYTES     = 3'h6;
   localparam logic [5:0] BURST_MAX        = 6'h20;
   localparam logic [9:0] COUNT_RESET      = 10'h000;

   typedef struct packed {
      logic       burst;
      logic       wrap_sel;
      logic       wrap_dis;
      logic [3:0] rate_divide_select;
   } rdbc_ctrl_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rdbc_bus_type;

   typedef enum logic [1:0] {
      ST_DIRECT = 2'b01,
      ST_DIVIDE = 2'b10
   } rdbc_state_type;

   typedef struct packed {
      rdbc_ctrl_type  ctrl;
      rdbc_state_type st;
      logic [9:0]     count;
      logic           out_stb;
      logic [7:0]     rdata;
      logic [7:0]     next_addr;
      logic [5:0]     samples;
   } rdbc_all_type;

   // Divide factor per code; zero means decimation off
   function automatic logic [9:0] rdbc_factor(input logic [3:0] c);
      case (c)
         4'h1:    rdbc_factor = 10'd2;
         4'h2:    rdbc_factor = 10'd4;
         4'h3:    rdbc_factor = 10'd5;
         4'h4:    rdbc_factor = 10'd8;
         4'h5:    rdbc_factor = 10'd10;
         4'h6:    rdbc_factor = 10'd16;
         4'h7:    rdbc_factor = 10'd20;
         4'h8:    rdbc_factor = 10'd40;
         4'h9:    rdbc_factor = 10'd67;
         4'ha:    rdbc_factor = 10'd80;
         4'hb:    rdbc_factor = 10'd100;
         4'hc:    rdbc_factor = 10'd200;
         4'hd:    rdbc_factor = 10'd250;
         4'he:    rdbc_factor = 10'd500;
         4'hf:    rdbc_factor = 10'd1000;
         default: rdbc_factor = 10'd0;
      endcase
   endfunction
endpackage

// [rdbc_ctrl.sv]
/*
 Rate decimation and burst read control register with its decimator
 and the register address pointer advance logic.
 Assumes internal sample strobes, bus strokes and FIFO read count all
 come from logic on sys_clk_i, one cycle pulses.
*/
// Functional notes
// - FIFO, motion and interrupts use decimated strobe; filter uses raw
// - Decimation off at reset; applies over any internal rate
// - Codes 0..7: off, divide 2, 4, 5, 8, 10, 16, 20
// - Codes 8..15: divide 40, 67, 80, 100, 200, 250, 500, 1000
// - Disabled decimation gives output rate equal to internal rate
// - Wrap-disable zero wraps pointer, one plain increments
// - Wrap to 0x0D after 0x12, or after 0x14 when selected
// - Burst clear: one six byte sample; set: up to 32 samples
`timescale 1ns/1ps
module rdbc_ctrl (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_i,
   input  wire rdbc_pkg::rdbc_bus_type bus_i,
   input  wire logic                  internal_sample_rate_i,
   input  wire logic [7:0]            ptr_addr_i,
   input  wire logic                  ptr_step_i,
   input  wire logic                  fifo_sample_done_i,
   input  wire logic                  xfer_start_i,
   input  wire logic [5:0]            read_count_i,
   output logic [7:0]                 rdata_o,
   output logic                       output_sample_rate_o,
   output logic [7:0]                 next_addr_o,
   output logic                       burst_end_o,
   output logic                       burst_mode_o
);
   import rdbc_pkg::*;

   rdbc_all_type s_q;
   rdbc_all_type s_d;
   logic [9:0]   factor;
   logic [7:0]   wrap_end;
   logic [5:0]   limit;
   logic         sel_change;

   // ==========================================================
   // Next state
   always_comb begin
      // =======================================================
      // Defaults
      // Hold every field; strobe is a one cycle pulse
      s_d         = s_q;
      s_d.out_stb = 1'b0;
      sel_change  = 1'b0;

      // =======================================================
      // Register write
      // Writes to any other offset are ignored
      if (bus_i.wr && bus_i.addr == CTRL_OFFSET) begin
         // Bit 6 is stored nowhere; it always reads zero
         s_d.ctrl.rate_divide_select = bus_i.wdata[DIV_LSB+:4];
         s_d.ctrl.wrap_dis = bus_i.wdata[WRAP_DIS_BIT];
         s_d.ctrl.wrap_sel = bus_i.wdata[WRAP_SEL_BIT];
         s_d.ctrl.burst    = bus_i.wdata[BURST_BIT];
         sel_change = bus_i.wdata[DIV_LSB+:4] !=
                      s_q.ctrl.rate_divide_select;
      end

      // =======================================================
      // Divide factor
      // Taken from the next value so a new code acts at once
      factor = rdbc_factor(s_d.ctrl.rate_divide_select);

      // =======================================================
      // Register read
      // Old value is returned when a write lands in the same cycle
      if (bus_i.rd && bus_i.addr == CTRL_OFFSET) begin
         s_d.rdata = {s_q.ctrl.burst, 1'b0, s_q.ctrl.wrap_sel,
                      s_q.ctrl.wrap_dis, s_q.ctrl.rate_divide_select};
      end else if (bus_i.rd) begin
         s_d.rdata = 8'h00;
      end

      // =======================================================
      // Decimator
      // Direct state echoes strobes; divide state counts them
      case (s_q.st)
         ST_DIRECT: begin
            s_d.out_stb = internal_sample_rate_i;
            if (factor != 10'd0) begin
               s_d.st    = ST_DIVIDE;
               s_d.count = COUNT_RESET;
               s_d.out_stb = 1'b0;
            end
         end
         ST_DIVIDE: begin
            if (factor == 10'd0) begin
               s_d.st = ST_DIRECT;
            end else if (sel_change) begin
               s_d.count = COUNT_RESET;
            end else if (internal_sample_rate_i) begin
               if (s_q.count == factor - 10'd1) begin
                  s_d.count   = COUNT_RESET;
                  s_d.out_stb = 1'b1;
               end else begin
                  s_d.count = s_q.count + 10'd1;
               end
            end
         end
         default: begin
            s_d.st    = ST_DIRECT;
            s_d.count = COUNT_RESET;
         end
      endcase

      // =======================================================
      // Address pointer advance
      // Wrap point follows the stored select bit only
      wrap_end = s_q.ctrl.wrap_sel ? WRAP_HIGH_END : WRAP_LOW_END;
      if (ptr_step_i) begin
         if (!s_q.ctrl.wrap_dis && ptr_addr_i == wrap_end) begin
            s_d.next_addr = WRAP_TARGET;
         end else begin
            s_d.next_addr = ptr_addr_i + 8'h01;
         end
      end

      // =======================================================
      // Burst sample count
      // Samples per FIFO read cycle; count of zero treated as one
      // Counts above the FIFO depth are clipped to it
      limit = 6'h01;
      if (s_q.ctrl.burst && read_count_i > 6'h01) begin
         limit = (read_count_i > BURST_MAX) ? BURST_MAX : read_count_i;
      end
      if (xfer_start_i) begin
         s_d.samples = 6'h00;
      end else if (fifo_sample_done_i && s_q.samples < limit) begin
         s_d.samples = s_q.samples + 6'h01;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q.ctrl      <= rdbc_ctrl_type'(CTRL_RESET[6:0]);
         s_q.st        <= ST_DIRECT;
         s_q.count     <= COUNT_RESET;
         s_q.out_stb   <= 1'b0;
         s_q.rdata     <= 8'h00;
         s_q.next_addr <= WRAP_TARGET;
         s_q.samples   <= 6'h00;
      end else begin
         s_q <= s_d;
      end
   end

   // Limitation: the sample size of six bytes is framed by the host port
   logic end_q;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         end_q <= 1'b0;
      end else begin
         end_q <= !xfer_start_i && s_d.samples == limit;
      end
   end

   assign rdata_o              = s_q.rdata;
   assign output_sample_rate_o = s_q.out_stb;
   assign next_addr_o          = s_q.next_addr;
   assign burst_end_o          = end_q;
   assign burst_mode_o         = s_q.ctrl.burst;
endmodule

// [rdbc_ctrl_assertions.sv]
/* Port checker for rdbc_ctrl.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module rdbc_chk import rdbc_pkg::*; (
   input wire logic         sys_clk_i,
   input wire logic         rst_i,
   input wire rdbc_bus_type bus_i,
   input wire logic         internal_sample_rate_i,
   input wire logic [7:0]   ptr_addr_i,
   input wire logic         ptr_step_i,
   input wire logic [7:0]   rdata_o,
   input wire logic         output_sample_rate_o,
   input wire logic [7:0]   next_addr_o,
   input wire logic         burst_mode_o
);
   logic [7:0] r_q;
   logic       w;
   // =============
   // Shadow register; bit 6 never stored
   assign w = bus_i.wr && bus_i.addr == CTRL_OFFSET;
   always_ff @(posedge sys_clk_i)
      r_q <= rst_i ? CTRL_RESET : (w ? bus_i.wdata & 8'hbf : r_q);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   read_back_a: assert property (bus_i.rd && bus_i.addr == CTRL_OFFSET
      |=> rdata_o == $past(r_q)) else $error("read value");
   burst_bit_a: assert property (burst_mode_o == r_q[7])
      else $error("burst mode");
   rate_echo_a: assert property (internal_sample_rate_i && r_q[3:0] == 0
      && !w |=> output_sample_rate_o) else $error("echo");
   no_source_a: assert property (!internal_sample_rate_i
      |=> !output_sample_rate_o) else $error("strobe");
   wrap_low_a: assert property (ptr_step_i && r_q[5:4] == 0 && !w
      && ptr_addr_i == 8'h12 |=> next_addr_o == 8'h0d) else $error("wrap");
   wrap_high_a: assert property (ptr_step_i && r_q[5:4] == 2 && !w
      && ptr_addr_i == 8'h14 |=> next_addr_o == 8'h0d) else $error("wrap");
   plain_step_a: assert property (ptr_step_i && r_q[4] && !w
      |=> next_addr_o == $past(ptr_addr_i) + 8'h01) else $error("step");
   reset_state_a: assert property ($fell(rst_i)
      |-> next_addr_o == 8'h0d && !burst_mode_o) else $error("reset");
endmodule
bind rdbc_ctrl rdbc_chk u_chk (.sys_clk_i, .rst_i, .bus_i,
   .internal_sample_rate_i, .ptr_addr_i, .ptr_step_i, .rdata_o,
   .output_sample_rate_o, .next_addr_o, .burst_mode_o);

// [rdbc_host_model.sv]
/* Host model draining FIFO samples until the burst ends.
   Assumes burst end rises a clock after the last sample. */
`timescale 1ns/1ps
module rdbc_host_model (
   input  wire logic  sys_clk_i,
   input  wire logic  go_i,
   input  wire logic  burst_end_i,
   output logic       xfer_start_o,
   output logic       fifo_sample_done_o,
   output logic [5:0] drained_o,
   output logic       busy_o
);
   // =============
   // One sample per four clocks; cap stops a burst that never ends
   initial begin
      {xfer_start_o, fifo_sample_done_o, busy_o, drained_o} = 9'h000;
      forever begin
         @(posedge sys_clk_i iff go_i);
         #1 {busy_o, xfer_start_o, drained_o} = 8'hc0;
         @(posedge sys_clk_i);
         #1 xfer_start_o = 0;
         while (!burst_end_i && drained_o < 6'h28) begin
            {fifo_sample_done_o, drained_o} = {1'b1, drained_o + 6'h01};
            @(posedge sys_clk_i);
            #1 fifo_sample_done_o = 0;
            repeat (3) @(posedge sys_clk_i);
            #1;
         end
         busy_o = 0;
      end
   end
endmodule

// [test_rate_decimation_and_burst_read_ctrl.sv]
/* Bench for rdbc_ctrl: register, decimation, pointer, burst.
   Assumes rdbc_host_model on the FIFO drain side. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module test_rate_decimation_and_burst_read_ctrl;
   import rdbc_pkg::*;
   logic clk = 0, rst = 1, isr = 0, ps = 0, go = 0, osr, xs, sd, be, bm, hb;
   rdbc_bus_type bus = '0;
   logic [7:0] pa = 8'h00, rq, nx;
   logic [7:0] wc [6] = '{8'h00, 8'h20, 8'h20, 8'h10, 8'h30, 8'h00};
   logic [7:0] wa [6] = '{8'h12, 8'h12, 8'h14, 8'h12, 8'h14, 8'h05};
   logic [7:0] we [6] = '{8'h0d, 8'h13, 8'h0d, 8'h13, 8'h15, 8'h06};
   int f [16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 100, 200, 250,
      500, 1000};
   int errors = 0, n_tests = 0;
   logic [5:0] rc = 6'h00, dr;
   logic [11:0] cnt;
   rdbc_ctrl u_rdbc_ctrl (.sys_clk_i(clk), .rst_i(rst), .bus_i(bus),
      .internal_sample_rate_i(isr), .ptr_addr_i(pa), .ptr_step_i(ps),
      .fifo_sample_done_i(sd), .xfer_start_i(xs), .read_count_i(rc),
      .rdata_o(rq), .output_sample_rate_o(osr), .next_addr_o(nx),
      .burst_end_o(be), .burst_mode_o(bm));
   rdbc_host_model u_rdbc_host_model (.sys_clk_i(clk), .go_i(go),
      .burst_end_i(be), .xfer_start_o(xs), .fifo_sample_done_o(sd),
      .drained_o(dr), .busy_o(hb));
   // =============
   // Access tasks
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] a, d);
      {bus.wr, bus.addr, bus.wdata} = {1'b1, a, d};
      tick();
      bus.wr = 0;
      tick();
   endtask
   task automatic rd(logic [7:0] a, e);
      {bus.rd, bus.addr} = {1'b1, a};
      tick();
      bus.rd = 0;
      `CHK("rdata", e, rq)
      tick();
   endtask
   task automatic drain(logic [5:0] e);
      go = 1;
      tick();
      go = 0;
      tick(2);
      for (int k = 0; k < 400 && hb; k++) tick();
      if (hb) begin errors++; print_verdict(); end
      `CHK("drained", e, dr)
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   initial begin
      tick(6);
      rst = 0;
      rd(8'h30, 8'h00);
      rd(8'h31, 8'h00);
      wr(8'h30, 8'hb5);
      rd(8'h30, 8'hb5);
      `CHK("burst_mode", 1'b1, bm)
      $display("test register done");
      for (int c = 0; c < 16; c++) begin
         wr(8'h30, 8'(c));
         {cnt, isr} = 13'h0001;
         repeat (2 * f[c]) begin tick(); cnt += osr; end
         isr = 0;
         tick();
         `CHK("out_strobes", 12'h002, cnt)
      end
      $display("test decimation done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h30, wc[i]);
         {pa, ps} = {wa[i], 1'b1};
         tick();
         ps = 0;
         `CHK("next_addr", we[i], nx)
      end
      $display("test pointer done");
      rc = 6'h03;
      wr(8'h30, 8'h80);
      drain(6'h03);
      wr(8'h30, 8'h00);
      drain(6'h01);
      $display("test burst done");
      print_verdict();
   end
endmodule
